// ==== hdl/tmc_pkg.sv ====
// Shared constants, types and carriers of the temperature monitor core
package tmc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADC_W   = 10;
    localparam int SAMP_W  = 13;
    localparam int TEMP_W  = 8;

    // ------------------------------------------------------------
    // Read map indices
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TEMP   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_CFG    = 8'h03;
    localparam logic [7:0] ADDR_RATE   = 8'h04;
    localparam logic [7:0] ADDR_HIGH   = 8'h05;
    localparam logic [7:0] ADDR_LOW    = 8'h06;
    localparam logic [7:0] ADDR_SHUT   = 8'h07;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_MASK_BIT  = 7;
    localparam int CFG_STBY_BIT  = 6;
    localparam int CFG_PIN_BIT   = 5;
    localparam int CFG_RANGE_BIT = 2;
    localparam int ST_HIGH_BIT   = 4;
    localparam int ST_LOW_BIT    = 3;
    localparam int ST_SHUT_BIT   = 1;
    localparam logic [7:0] TEMP_RST   = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] RD_RST     = 8'h00;

    // ------------------------------------------------------------
    // Averaging, range limits and fast rate codes
    // ------------------------------------------------------------
    localparam int AVG_LEN    = 16;
    localparam int AVG_SHIFT  = 4;
    localparam int EXT_OFFSET = 64;
    localparam int EXT_MIN    = -64;
    localparam int EXT_MAX    = 191;
    localparam int DEF_MIN    = 0;
    localparam int DEF_MAX    = 127;
    localparam logic [7:0] RATE_16HZ = 8'h08;
    localparam logic [7:0] RATE_32HZ = 8'h09;
    localparam logic [7:0] RATE_64HZ = 8'h0A;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CUR_BASE, CUR_N1, CUR_N2} tmc_cur_e;

    typedef struct packed {
        logic irq_mask_bit;
        logic standby;
        logic pin_func;
        logic ext_range;
    } tmc_cfg_s;

    typedef struct packed {
        logic signed [ADC_W:0] delta1;
        logic signed [ADC_W:0] delta2;
    } tmc_meas_s;

endpackage

// ==== hdl/tmc_sync.sv ====
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module tmc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        meta_reg <= d;
        q        <= meta_reg;
    end
endmodule

// ==== hdl/tmc_front.sv ====
// Sensor current sequencer on the converter clock
`timescale 1ns/1ps
module tmc_front
    import tmc_pkg::*;
(
    input  wire logic              adc_clk,
    input  wire logic              adc_rst_n,
    input  wire logic              run,
    input  wire logic              adc_done,
    input  wire logic [ADC_W-1:0]  adc_data,
    input  wire logic              ack_tgl,
    output tmc_pkg::tmc_cur_e      cur_sel,
    output tmc_pkg::tmc_meas_s     meas,
    output logic                   req_tgl
);
    typedef enum {ST_IDLE, ST_BASE1, ST_MULT1, ST_BASE2, ST_MULT2, ST_HOLD} tmc_ph_e;

    tmc_ph_e          state_reg;
    logic [ADC_W-1:0] base_reg;
    logic [ADC_W-1:0] mult1_reg;

    function automatic logic signed [ADC_W:0] diff(input logic [ADC_W-1:0] hi,
                                                   input logic [ADC_W-1:0] lo);
        diff = $signed({1'b0, hi}) - $signed({1'b0, lo});
    endfunction

    // ------------------------------------------------------------
    // Current phases: base, N1, base, N2, then hand over
    // ------------------------------------------------------------
    always_ff @(posedge adc_clk) begin
        if (!adc_rst_n) begin
            state_reg <= ST_IDLE;
            base_reg  <= '0;
            mult1_reg <= '0;
            meas      <= '0;
            req_tgl   <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (run) begin
                        state_reg <= ST_BASE1;
                    end
                end
                ST_BASE1: begin
                    if (adc_done) begin
                        base_reg  <= adc_data;
                        state_reg <= ST_MULT1;
                    end
                end
                ST_MULT1: begin
                    if (adc_done) begin
                        mult1_reg <= adc_data;
                        state_reg <= ST_BASE2;
                    end
                end
                ST_BASE2: begin
                    if (adc_done) begin
                        meas.delta1 <= diff(mult1_reg, base_reg);
                        base_reg    <= adc_data;
                        state_reg   <= ST_MULT2;
                    end
                end
                ST_MULT2: begin
                    if (adc_done) begin
                        meas.delta2 <= diff(adc_data, base_reg);
                        req_tgl     <= ~req_tgl;
                        state_reg   <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // Restart without any trigger once the word is taken while run is high, else go idle
                    if (ack_tgl == req_tgl) begin
                        state_reg <= run ? ST_BASE1 : ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_comb begin
        case (state_reg)
            ST_MULT1: cur_sel = CUR_N1;
            ST_MULT2: cur_sel = CUR_N2;
            default:  cur_sel = CUR_BASE;
        endcase
    end

    a_restart_free: assert property (@(posedge adc_clk) disable iff (!adc_rst_n)
        state_reg == ST_HOLD && ack_tgl == req_tgl && run |=> state_reg == ST_BASE1)
        else $error("Sequencer did not restart after hand over");
endmodule

// ==== hdl/tmc_core.sv ====
// Measurement, averaging, limit compare and alarm outputs of the monitor
//
// Function
// - The converter runs freely, each conversion starting when the last ends.
// - Every completed result is written into the temperature value register.
// - A measurement steps base/N1 then base/N2 current and uses both differences.
// - At low conversion rates each result is the mean of 16 measurements.
// - At 16, 32 and 64 conversions per second each measurement is reported as is.
// - Each result is compared with high, low and shutdown limits, setting flags.
// - A result above the high or below the low limit asserts the limit interrupt.
// - A result above the shutdown limit drives the shutdown output low.
// - The interrupt pin can act as a second shutdown comparator output.
// - Limits and controls come from the host, and any register reads back.
// - Standby, range, mask, pin function and conversion rate are host controls.
// - In standby conversion stops while reads and alarm outputs stay live.
// - Pin function 0 gives the limit interrupt and 1 the second shutdown.
// - Mask set to 1 silences the interrupt but not the second shutdown.
// - Extended range is offset binary by 64, default range is clamped 0 to 127.
`timescale 1ns/1ps
module tmc_core
    import tmc_pkg::*;
#(
    parameter int TEMP_OFFSET = 0
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              adc_clk,
    input  wire logic              adc_done,
    input  wire logic [ADC_W-1:0]  adc_data,
    output tmc_pkg::tmc_cur_e      sense_cur_sel,
    input  tmc_pkg::tmc_cfg_s      cfg,
    input  wire logic [7:0]        conv_rate,
    input  wire logic [7:0]        high_limit,
    input  wire logic [7:0]        low_limit,
    input  wire logic [7:0]        shut_limit,
    input  wire logic [7:0]        rd_addr,
    input  wire logic              rd_strobe,
    output logic      [7:0]        rd_data,
    output logic      [7:0]        temp_value,
    output logic                   result_valid,
    output logic                   alert_n,
    output logic                   alert_oe,
    output logic                   overtemp_shutdown_n,
    output logic                   overtemp_shutdown_oe
);
    import tmc_pkg::*;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic is_fast_rate(input logic [7:0] code);
        is_fast_rate = (code == RATE_16HZ) || (code == RATE_32HZ) || (code == RATE_64HZ);
    endfunction

    function automatic logic [7:0] encode_temp(input logic signed [SAMP_W-1:0] t,
                                               input logic ext);
        if (ext) begin
            if (t < EXT_MIN) begin
                encode_temp = 8'h00;
            end else if (t > EXT_MAX) begin
                encode_temp = 8'hFF;
            end else begin
                encode_temp = 8'(t + EXT_OFFSET);
            end
        end else begin
            if (t < DEF_MIN) begin
                encode_temp = 8'h00;
            end else if (t > DEF_MAX) begin
                encode_temp = 8'(DEF_MAX);
            end else begin
                encode_temp = 8'(t);
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Converter domain and crossings
    // ------------------------------------------------------------
    logic      run_reg;
    logic      ack_tgl_reg;
    logic      adc_rst_n;
    logic      run_adc;
    logic      ack_adc;
    logic      req_tgl;
    logic      req_ref;
    tmc_meas_s meas;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= ~cfg.standby;
        end
    end

    tmc_sync #(.W(1)) u_rst_sync (
        .clk (adc_clk),
        .d   (resetn),
        .q   (adc_rst_n)
    );

    tmc_sync #(.W(2)) u_ctl_sync (
        .clk (adc_clk),
        .d   ({run_reg, ack_tgl_reg}),
        .q   ({run_adc, ack_adc})
    );

    tmc_front u_front (
        .adc_clk   (adc_clk),
        .adc_rst_n (adc_rst_n),
        .run       (run_adc),
        .adc_done  (adc_done),
        .adc_data  (adc_data),
        .ack_tgl   (ack_adc),
        .cur_sel   (sense_cur_sel),
        .meas      (meas),
        .req_tgl   (req_tgl)
    );

    tmc_sync #(.W(1)) u_req_sync (
        .clk (ref_clk),
        .d   (req_tgl),
        .q   (req_ref)
    );

    // ------------------------------------------------------------
    // Take the measurement word
    // ------------------------------------------------------------
    logic                     new_meas;
    logic                     samp_vld_reg;
    logic signed [SAMP_W-1:0] samp_reg;
    logic signed [SAMP_W-1:0] samp_next;

    // Word is held stable by the sequencer until the ack toggles back
    assign new_meas  = req_ref != ack_tgl_reg;
    assign samp_next = SAMP_W'(meas.delta2) - SAMP_W'(meas.delta1)
                       - SAMP_W'(TEMP_OFFSET);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ack_tgl_reg  <= 1'b0;
            samp_vld_reg <= 1'b0;
            samp_reg     <= '0;
        end else begin
            samp_vld_reg <= new_meas;
            if (new_meas) begin
                ack_tgl_reg <= req_ref;
                samp_reg    <= samp_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Averaging
    // ------------------------------------------------------------
    localparam int SUM_W = SAMP_W + AVG_SHIFT;

    logic                      fast;
    logic [AVG_SHIFT-1:0]      avg_cnt_reg;
    logic signed [SUM_W-1:0]   sum_reg;
    logic signed [SUM_W-1:0]   sum_next;
    logic                      res_vld_reg;
    logic signed [SAMP_W-1:0]  res_reg;

    assign fast     = is_fast_rate(conv_rate);
    assign sum_next = sum_reg + SUM_W'(samp_reg);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            avg_cnt_reg <= '0;
            sum_reg     <= '0;
            res_vld_reg <= 1'b0;
            res_reg     <= '0;
        end else begin
            res_vld_reg <= 1'b0;
            if (cfg.standby || fast) begin
                avg_cnt_reg <= '0;
                sum_reg     <= '0;
            end
            if (samp_vld_reg) begin
                if (fast) begin
                    res_reg     <= samp_reg;
                    res_vld_reg <= 1'b1;
                end else if (avg_cnt_reg == AVG_SHIFT'(AVG_LEN - 1)) begin
                    res_reg     <= SAMP_W'(sum_next >>> AVG_SHIFT);
                    res_vld_reg <= 1'b1;
                    avg_cnt_reg <= '0;
                    sum_reg     <= '0;
                end else begin
                    avg_cnt_reg <= avg_cnt_reg + 1'b1;
                    sum_reg     <= sum_next;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Store, compare and flag
    // ------------------------------------------------------------
    logic [7:0] enc;
    logic [7:0] temp_reg;
    logic [7:0] status_reg;
    logic       shut_act_reg;
    logic       second_act_reg;
    logic       st_clear;

    assign enc      = encode_temp(res_reg, cfg.ext_range);
    assign st_clear = rd_strobe && (rd_addr == ADDR_STATUS);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            temp_reg <= TEMP_RST;
        end else if (res_vld_reg) begin
            temp_reg <= enc;
        end
    end

    // Read clears flags; a result in the same cycle wins
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            status_reg <= STATUS_RST;
        end else begin
            if (st_clear) begin
                status_reg <= STATUS_RST;
            end
            if (res_vld_reg) begin
                if (enc > high_limit) begin
                    status_reg[ST_HIGH_BIT] <= 1'b1;
                end
                if (enc < low_limit) begin
                    status_reg[ST_LOW_BIT] <= 1'b1;
                end
                if (enc > shut_limit) begin
                    status_reg[ST_SHUT_BIT] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            shut_act_reg   <= 1'b0;
            second_act_reg <= 1'b0;
        end else if (res_vld_reg) begin
            shut_act_reg   <= enc > shut_limit;
            second_act_reg <= enc > high_limit;
        end else begin
            // Limit changes act at once, in standby too
            shut_act_reg   <= temp_reg > shut_limit;
            second_act_reg <= temp_reg > high_limit;
        end
    end

    // ------------------------------------------------------------
    // Alarm pins
    // ------------------------------------------------------------
    logic alert_cond;

    always_comb begin
        if (cfg.pin_func) begin
            alert_cond = second_act_reg;
        end else begin
            alert_cond = (status_reg[ST_HIGH_BIT] || status_reg[ST_LOW_BIT])
                         && !cfg.irq_mask_bit;
        end
    end

    assign alert_n              = ~alert_cond;
    assign alert_oe             = alert_cond;
    assign overtemp_shutdown_n  = ~shut_act_reg;
    assign overtemp_shutdown_oe = shut_act_reg;
    assign temp_value           = temp_reg;
    assign result_valid         = res_vld_reg;

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    logic [7:0] cfg_rd;

    always_comb begin
        cfg_rd                = 8'h00;
        cfg_rd[CFG_MASK_BIT]  = cfg.irq_mask_bit;
        cfg_rd[CFG_STBY_BIT]  = cfg.standby;
        cfg_rd[CFG_PIN_BIT]   = cfg.pin_func;
        cfg_rd[CFG_RANGE_BIT] = cfg.ext_range;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rd_data <= RD_RST;
        end else if (rd_strobe) begin
            case (rd_addr)
                ADDR_TEMP:   rd_data <= temp_reg;
                ADDR_STATUS: rd_data <= status_reg;
                ADDR_CFG:    rd_data <= cfg_rd;
                ADDR_RATE:   rd_data <= conv_rate;
                ADDR_HIGH:   rd_data <= high_limit;
                ADDR_LOW:    rd_data <= low_limit;
                ADDR_SHUT:   rd_data <= shut_limit;
                default:     rd_data <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_shut_assert: assert property (@(posedge ref_clk) disable iff (!resetn)
        res_vld_reg && enc > shut_limit |=> !overtemp_shutdown_n)
        else $error("Shutdown not asserted above limit");

    a_flag_high: assert property (@(posedge ref_clk) disable iff (!resetn)
        res_vld_reg && enc > high_limit |=> status_reg[ST_HIGH_BIT])
        else $error("High flag missing");

    a_flag_low: assert property (@(posedge ref_clk) disable iff (!resetn)
        res_vld_reg && enc < low_limit |=> status_reg[ST_LOW_BIT])
        else $error("Low flag missing");

    a_alert_raise: assert property (@(posedge ref_clk) disable iff (!resetn)
        res_vld_reg && enc > high_limit && !cfg.pin_func && !cfg.irq_mask_bit
        ##1 !cfg.pin_func && !cfg.irq_mask_bit |-> !alert_n)
        else $error("Interrupt not asserted on limit violation");

    a_mask_silence: assert property (@(posedge ref_clk) disable iff (!resetn)
        cfg.irq_mask_bit && !cfg.pin_func |-> alert_n && !alert_oe)
        else $error("Masked interrupt still driven");

    a_second_shut: assert property (@(posedge ref_clk) disable iff (!resetn)
        res_vld_reg && enc > high_limit ##1 cfg.pin_func |-> !alert_n)
        else $error("Second shutdown pin not asserted above limit");

    a_default_clamp: assert property (@(posedge ref_clk) disable iff (!resetn)
        res_vld_reg && !cfg.ext_range |=> temp_reg <= 8'h7F)
        else $error("Default range result above 127");

    a_fast_direct: assert property (@(posedge ref_clk) disable iff (!resetn)
        samp_vld_reg && fast |=> res_vld_reg && res_reg == $past(samp_reg))
        else $error("Fast rate result not direct");

    a_avg_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        samp_vld_reg && !fast && avg_cnt_reg != 4'hF |=> !res_vld_reg)
        else $error("Averaged result issued early");

    a_temp_store: assert property (@(posedge ref_clk) disable iff (!resetn)
        res_vld_reg |=> temp_reg == $past(enc) ##1 temp_reg == $past(temp_reg) || res_vld_reg)
        else $error("Temperature register not updated with result");
endmodule

// ==== verif/tmc_adc_model.sv ====
// Converter and sensor stand-in answering each current phase
`timescale 1ns/1ps
module tmc_adc_model
    import tmc_pkg::*;
(
    input  wire logic             adc_clk,
    input  tmc_pkg::tmc_cur_e     sel,
    input  wire logic [ADC_W-1:0] temp,
    input  wire logic             jit_en,
    input  wire logic             slow,
    output logic                  adc_done,
    output logic      [ADC_W-1:0] adc_data
);
    logic [1:0] wait_reg = 2'h0;
    logic [3:0] jit_reg  = 4'h0;
    initial adc_done = 1'b0;
    initial adc_data = 10'h000;
    // Data line flips while no sample is offered
    always @(posedge adc_clk) begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        wait_reg <= wait_reg - 2'h1;
        if (wait_reg == 2'h0) begin
            adc_done <= 1'b1;
            wait_reg <= slow ? 2'h3 : 2'h1;
            case (sel)
                CUR_N1:  adc_data <= 10'h12C;
                CUR_N2:  adc_data <= 10'h12C + temp + 10'(jit_en ? jit_reg : 4'h0);
                default: adc_data <= 10'h0C8;
            endcase
            if (sel == CUR_N2) jit_reg <= jit_reg + 4'h1;
        end
    end
endmodule

// ==== verif/temp_monitor_core_tb_top.sv ====
// Self-checking bench of the temperature monitor core
`timescale 1ns/1ps
module temp_monitor_core_tb_top;
    import tmc_pkg::*;
    logic ref_clk = 0, adc_clk = 0, resetn = 0, rd_strobe = 0, jit_en = 0, slow = 0;
    logic adc_done, result_valid, alert_n, alert_oe, sd_n, sd_oe, al;
    logic [ADC_W-1:0] adc_data, temp = '0;
    logic [7:0] conv_rate = 8'h08, hi = 8'hFF, lo = 8'h00, th = 8'hFF, rd_addr = 8'h00;
    logic [7:0] rd_data, temp_value;
    tmc_cfg_s cfg = '0;
    tmc_cur_e sel;
    int fails = 0, checked = 0, cyc = 0, nres = 0, t, e;
    logic [7:0] rates [4] = '{8'h08, 8'h09, 8'h0A, 8'h04};
    always #10 ref_clk = ~ref_clk;
    always #16 adc_clk = ~adc_clk;
    tmc_core tmc_core_inst (.ref_clk(ref_clk), .resetn(resetn), .adc_clk(adc_clk),
        .adc_done(adc_done), .adc_data(adc_data), .sense_cur_sel(sel), .cfg(cfg),
        .conv_rate(conv_rate), .high_limit(hi), .low_limit(lo), .shut_limit(th),
        .rd_addr(rd_addr), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .temp_value(temp_value), .result_valid(result_valid), .alert_n(alert_n),
        .alert_oe(alert_oe), .overtemp_shutdown_n(sd_n), .overtemp_shutdown_oe(sd_oe));
    tmc_adc_model tmc_adc_model_inst (.adc_clk(adc_clk), .sel(sel), .temp(temp),
        .jit_en(jit_en), .slow(slow), .adc_done(adc_done), .adc_data(adc_data));
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] enc(input int v, input bit ext);
        if (ext) return 8'((v < EXT_MIN ? EXT_MIN : v > EXT_MAX ? EXT_MAX : v) + EXT_OFFSET);
        return 8'(v < DEF_MIN ? DEF_MIN : v > DEF_MAX ? DEF_MAX : v);
    endfunction
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        rd_addr = a;
        rd_strobe = 1'b1;
        @(posedge ref_clk);
        #2 rd_strobe = 1'b0;
        chk(nm, rd_data, exp);
        @(posedge ref_clk);
        #2;
    endtask
    task automatic wait_res(input int n);
        int k = 0;
        while (n > 0 && k < 3000) begin
            @(posedge ref_clk);
            k++;
            if (result_valid === 1'b1) n--;
        end
        #2 chk("result count", 8'(n), 8'h00);
    endtask
    task automatic conclude();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        nres += (result_valid === 1'b1);
        if (cyc == 60000) begin
            fails++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h56dfb95b));
        repeat (5) @(posedge ref_clk);
        #2 resetn = 1'b1;
        chk("temp after reset", temp_value, TEMP_RST);
        chk("alarms after reset", {alert_n, alert_oe, sd_n, sd_oe}, 8'h0A);
        for (int i = 0; i < 8; i++) begin
            t = (i == 0) ? -80 : (i == 1) ? 200 : int'($urandom_range(280)) - 80;
            conv_rate = rates[i % 4];
            jit_en = (i % 4 == 3);
            slow = $urandom_range(1);
            cfg = tmc_cfg_s'($urandom_range(15) & 4'hB);
            temp = 10'(t);
            e = enc(t + (jit_en ? 7 : 0), cfg.ext_range);
            hi = 8'(e - 1 + $urandom_range(2));
            lo = 8'(e - 1 + $urandom_range(2));
            th = 8'(e - 1 + $urandom_range(2));
            wait_res(jit_en ? 2 : 3);
            chk("temp value", temp_value, 8'(e));
            rd_addr = ADDR_STATUS;
            rd_strobe = 1'b1;
            @(posedge ref_clk);
            #2 rd_strobe = 1'b0;
            chk("status spare bits", rd_data & 8'hE5, 8'h00);
            wait_res(1);
            al = cfg.pin_func ? e > hi : (e > hi || e < lo) && !cfg.irq_mask_bit;
            chk("shutdown", sd_n, {7'h0, ~(e > th)});
            chk("shutdown oe", sd_oe, {7'h0, e > th});
            chk("alert", alert_n, {7'h0, ~al});
            chk("alert oe", alert_oe, {7'h0, al});
            rd(ADDR_STATUS, {3'h0, e > hi, e < lo, 1'b0, e > th, 1'b0},
                "status");
            if (!cfg.pin_func) chk("alert released", alert_n, 8'h01);
            rd(ADDR_TEMP, 8'(e), "temp read");
            rd(ADDR_CFG, {cfg.irq_mask_bit, cfg.standby, cfg.pin_func, 2'b00,
                cfg.ext_range, 2'b00}, "config");
            rd(ADDR_RATE, conv_rate, "rate");
            rd(ADDR_HIGH, hi, "high");
            rd(ADDR_LOW, lo, "low");
            rd(ADDR_SHUT, th, "shut limit");
            rd(8'h01, 8'h00, "unmapped");
        end
        th = 8'h00;
        cfg.standby = 1'b1;
        repeat (200) @(posedge ref_clk);
        #2 nres = 0;
        repeat (400) @(posedge ref_clk);
        #2 chk("standby results", 8'(nres), 8'h00);
        chk("standby shutdown", sd_n, {7'h0, ~(e > th)});
        rd(ADDR_CFG, {cfg.irq_mask_bit, cfg.standby, cfg.pin_func, 2'b00,
            cfg.ext_range, 2'b00}, "standby config");
        cfg.standby = 1'b0;
        wait_res(2);
        conclude();
    end
endmodule
